// ==== rtl/pwr_mode_pkg.sv ====
// constants, register map and carrier types of the power-down mode controller
package pwr_mode_pkg;

	// register byte offsets on the APB
	localparam logic [11:0] OFS_SYS_CTRL_1 = 12'h000;
	localparam logic [11:0] OFS_SYS_CTRL_2 = 12'h004;
	localparam logic [11:0] OFS_MOD_STANDBY = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00C;

	// system_control_1 fields
	localparam int SC1_SETTLE_LSB = 4;
	localparam int SC1_DEEP_STOP_BIT = 7;
	// system_control_2 fields
	localparam int SC2_ACTIVE_SEL_LSB = 0;
	localparam int SC2_SUB_DIV_LSB = 3;
	localparam int SC2_LOW_SPEED_BIT = 5;
	localparam int SC2_SUB_SLEEP_BIT = 6;
	localparam int SC2_DIRECT_BIT = 7;

	// reset values
	localparam logic [7:0] SYS_CTRL_1_RST = 8'h00;
	localparam logic [7:0] SYS_CTRL_2_RST = 8'h00;

	// SLEEP execution states plus internal processing states
	localparam int SLEEP_EXEC_STATES = 2;
	localparam int INTERNAL_STATES = 1;
	localparam logic [3:0] SWITCH_CYCLES =
		4'(SLEEP_EXEC_STATES + INTERNAL_STATES);

	// clock rate of clk_sys
	localparam int CLK_MHZ = 100;
	localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

	localparam int SETTLE_CNT_W = 24;

	typedef enum logic [2:0] {
		MODE_ACTIVE = 3'b000,
		MODE_SLEEP = 3'b001,
		MODE_SUBSLEEP = 3'b011,
		MODE_SUBACTIVE = 3'b010,
		MODE_STANDBY = 3'b110,
		MODE_SETTLE = 3'b111,
		MODE_SWITCH = 3'b101,
		MODE_PIN_RESET = 3'b100
	} pm_mode_e;

	// clock selection in force
	typedef struct packed {
		logic lowSpeed;
		logic [2:0] activeClockSel;
		logic [1:0] subClockDiv;
	} clk_sel_s;

	// controls toward CPU, clock generator and ports
	typedef struct packed {
		logic cpuHalt;
		logic cpuResetHold;
		logic sysOscRun;
		logic portHighZ;
		logic portHold;
		logic intExcStart;
		logic directExcStart;
	} pm_ctrl_s;

endpackage

// ==== rtl/power_down_mode_control.sv ====
// power-down mode controller with APB registers and clock gating controls
//
// Summary of operation
// - sleep halts CPU, peripherals run at active clock
// - enabled unmasked interrupt ends sleep, starts exception
// - leaving sleep: active if low-speed 0, else subactive
// - clear pin low in sleep resets CPU, ends sleep
// - standby stops clocks, ports go high impedance
// - standby wake restarts oscillator, waits settle time
// - masked or disabled interrupt keeps standby
// - clear pin restarts oscillator; held low until stable
// - subsleep halts all but timer A, ports held
// - enabled unmasked interrupt ends subsleep, starts exception
// - leaving subsleep: active if low-speed 0, else subactive
// - subactive CPU clock is watch clock /2,/4,/8
// - new divider settings apply only after SLEEP
// - SLEEP in subactive reaches any mode per selects
// - direct switch goes to active if low-speed 0, else subactive, then exception
// - direct interrupt disabled: sleep or subsleep instead
// - direct switch while masked: sleep/subsleep, no wake
// - active to sub: switch states, then sub clock
// - sub to active: switch states, settle, then handling
// - per-module standby bit gates that module clock
// - SLEEP target: direct, else standby, else sleep/subsleep
`timescale 1ns/1ps

module power_down_mode_control #(
	parameter int NUM_MODULES = 8,
	parameter int TIMER_A_INDEX = 0,
	parameter int SETTLE_UNIT = 1024
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleepExec,
	input wire logic intRequest,
	input wire logic intEnabled,
	input wire logic intMask,
	input wire logic directIntEnabled,
	input wire logic hardwareClearPin_n,
	output pwr_mode_pkg::pm_ctrl_s ctrl,
	output pwr_mode_pkg::clk_sel_s clkSel,
	output logic [NUM_MODULES-1:0] moduleClockEn,
	output pwr_mode_pkg::pm_mode_e mode
);

	// refuse parameter values the logic cannot serve
	if (NUM_MODULES < 1 || NUM_MODULES > 32) begin : g_bad_modules
		$error("NUM_MODULES must be 1 to 32");
	end
	if (TIMER_A_INDEX < 0 ||
		TIMER_A_INDEX >= NUM_MODULES) begin : g_bad_timer
		$error("TIMER_A_INDEX out of range");
	end
	if (SETTLE_UNIT < 1 || SETTLE_UNIT > 65536) begin : g_bad_settle
		$error("SETTLE_UNIT must be 1 to 65536");
	end

	// registers
	logic [7:0] sysCtrl1_r;
	logic [7:0] sysCtrl2_r;
	logic [NUM_MODULES-1:0] modStandby_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	pwr_mode_pkg::pm_mode_e mode_r;
	pwr_mode_pkg::pm_mode_e mode_nxt;
	pwr_mode_pkg::pm_ctrl_s ctrl_r;
	pwr_mode_pkg::pm_ctrl_s ctrl_nxt;
	pwr_mode_pkg::clk_sel_s clkSel_r;
	pwr_mode_pkg::clk_sel_s clkSel_nxt;
	logic [NUM_MODULES-1:0] clkEn_r;
	logic [pwr_mode_pkg::SETTLE_CNT_W-1:0] cnt_r;
	logic [pwr_mode_pkg::SETTLE_CNT_W-1:0] cnt_nxt;
	logic noWake_r;
	logic noWake_nxt;
	logic directPend_r;
	logic directPend_nxt;
	logic switchFromSub_r;

	// register fields
	wire [2:0] settleSel = sysCtrl1_r[pwr_mode_pkg::SC1_SETTLE_LSB +: 3];
	wire deepStop = sysCtrl1_r[pwr_mode_pkg::SC1_DEEP_STOP_BIT];
	wire [2:0] activeSel = sysCtrl2_r[pwr_mode_pkg::SC2_ACTIVE_SEL_LSB +: 3];
	wire [1:0] subDiv = sysCtrl2_r[pwr_mode_pkg::SC2_SUB_DIV_LSB +: 2];
	wire lowSpeed = sysCtrl2_r[pwr_mode_pkg::SC2_LOW_SPEED_BIT];
	wire subSleep = sysCtrl2_r[pwr_mode_pkg::SC2_SUB_SLEEP_BIT];
	wire directSw = sysCtrl2_r[pwr_mode_pkg::SC2_DIRECT_BIT];

	// APB decode
	wire setupPhase = psel & ~penable;
	wire apbDone = psel & penable & pready_r;
	wire hitSc1 = paddr == pwr_mode_pkg::OFS_SYS_CTRL_1;
	wire hitSc2 = paddr == pwr_mode_pkg::OFS_SYS_CTRL_2;
	wire hitMsb = paddr == pwr_mode_pkg::OFS_MOD_STANDBY;
	wire hitSts = paddr == pwr_mode_pkg::OFS_STATUS;
	wire hitAny = hitSc1 | hitSc2 | hitMsb | hitSts;
	wire wrSc1 = apbDone & pwrite & hitSc1;
	wire wrSc2 = apbDone & pwrite & hitSc2;
	wire wrMsb = apbDone & pwrite & hitMsb;
	wire [31:0] modStandbyWord = 32'(modStandby_r);
	// status: mode, direct switch pending, no-wake flag
	wire [31:0] statusWord = {
		26'h0,
		noWake_r,
		directPend_r,
		1'b0,
		mode_r
	};
	wire [31:0] readMux =
		hitSc1 ? {24'h0, sysCtrl1_r} :
		hitSc2 ? {24'h0, sysCtrl2_r} :
		hitMsb ? modStandbyWord :
		hitSts ? statusWord : 32'h0000_0000;

	// wake and SLEEP decisions
	wire pinLow = ~hardwareClearPin_n;
	// the no-wake flag keeps a masked direct switch asleep until the pin
	wire wakeReq = intRequest & intEnabled & ~intMask
		& ~noWake_r;
	wire directOk = directIntEnabled & ~intMask;
	// mode after an interrupt or a direct switch
	wire pwr_mode_pkg::pm_mode_e runMode = lowSpeed
		? pwr_mode_pkg::MODE_SUBACTIVE
		: pwr_mode_pkg::MODE_ACTIVE;
	wire pwr_mode_pkg::pm_mode_e napMode = subSleep
		? pwr_mode_pkg::MODE_SUBSLEEP
		: pwr_mode_pkg::MODE_SLEEP;
	wire [pwr_mode_pkg::SETTLE_CNT_W-1:0] settleCycles =
		pwr_mode_pkg::SETTLE_CNT_W'(SETTLE_UNIT) << settleSel;
	// length of the switch states, run at the old clock
	wire [pwr_mode_pkg::SETTLE_CNT_W-1:0] switchCycles =
		pwr_mode_pkg::SETTLE_CNT_W'(pwr_mode_pkg::SWITCH_CYCLES);
	wire cntZero = cnt_r == '0;
	wire fromSub = mode_r == pwr_mode_pkg::MODE_SUBACTIVE;
	// side a direct switch started from: live on entry, held inside
	wire fromSubSwitch = (mode_r == pwr_mode_pkg::MODE_SWITCH) ?
		switchFromSub_r : fromSub;

	// divider settings latched at SLEEP only
	always_comb begin
		clkSel_nxt = clkSel_r;
		if (sleepExec && (mode_r == pwr_mode_pkg::MODE_ACTIVE ||
			mode_r == pwr_mode_pkg::MODE_SUBACTIVE)) begin
			clkSel_nxt.activeClockSel = activeSel;
			clkSel_nxt.subClockDiv = subDiv;
			clkSel_nxt.lowSpeed = clkSel_r.lowSpeed;
		end
		if (mode_nxt == pwr_mode_pkg::MODE_SUBACTIVE)
			clkSel_nxt.lowSpeed = 1'b1;
		else if (mode_nxt == pwr_mode_pkg::MODE_ACTIVE ||
			mode_nxt == pwr_mode_pkg::MODE_PIN_RESET)
			clkSel_nxt.lowSpeed = 1'b0;
	end

	// mode sequencer
	always_comb begin
		mode_nxt = mode_r;
		// counter runs down to zero and rests there
		cnt_nxt = cntZero ? cnt_r : cnt_r - 1'b1;
		noWake_nxt = noWake_r;
		directPend_nxt = directPend_r;
		ctrl_nxt = '0;
		case (mode_r)
			pwr_mode_pkg::MODE_ACTIVE,
			pwr_mode_pkg::MODE_SUBACTIVE: begin
				if (sleepExec) begin
					if (directSw && directOk) begin
						// old clock keeps running through the switch states
						mode_nxt = pwr_mode_pkg::MODE_SWITCH;
						cnt_nxt = switchCycles;
						directPend_nxt = 1'b1;
					end else if (directSw) begin
						mode_nxt = napMode;
						noWake_nxt = intMask;
					end else if (deepStop) begin
						mode_nxt = pwr_mode_pkg::MODE_STANDBY;
					end else begin
						mode_nxt = napMode;
					end
				end
			end
			pwr_mode_pkg::MODE_SWITCH: begin
				if (cntZero) begin
					// going up to the system clock needs the settle wait
					if (fromSubSwitch && !lowSpeed) begin
						mode_nxt = pwr_mode_pkg::MODE_SETTLE;
						cnt_nxt = settleCycles;
					end else begin
						mode_nxt = runMode;
						directPend_nxt = 1'b0;
						ctrl_nxt.directExcStart = 1'b1;
					end
				end
			end
			pwr_mode_pkg::MODE_SLEEP,
			pwr_mode_pkg::MODE_SUBSLEEP: begin
				if (wakeReq) begin
					mode_nxt = runMode;
					ctrl_nxt.intExcStart = 1'b1;
				end
			end
			pwr_mode_pkg::MODE_STANDBY: begin
				if (wakeReq) begin
					mode_nxt = pwr_mode_pkg::MODE_SETTLE;
					cnt_nxt = settleCycles;
				end
			end
			pwr_mode_pkg::MODE_SETTLE: begin
				if (cntZero) begin
					mode_nxt = pwr_mode_pkg::MODE_ACTIVE;
					if (directPend_r)
						ctrl_nxt.directExcStart = 1'b1;
					else
						ctrl_nxt.intExcStart = 1'b1;
					directPend_nxt = 1'b0;
				end
			end
			pwr_mode_pkg::MODE_PIN_RESET: begin
				if (!pinLow)
					mode_nxt = pwr_mode_pkg::MODE_ACTIVE;
			end
			default: begin
				mode_nxt = pwr_mode_pkg::MODE_ACTIVE;
			end
		endcase
		if (pinLow) begin
			// oscillator restarts at once; the pin holder waits it out
			mode_nxt = pwr_mode_pkg::MODE_PIN_RESET;
			noWake_nxt = 1'b0;
			directPend_nxt = 1'b0;
			cnt_nxt = '0;
			ctrl_nxt.intExcStart = 1'b0;
			ctrl_nxt.directExcStart = 1'b0;
		end
		// level controls follow the mode being entered
		case (mode_nxt)
			pwr_mode_pkg::MODE_SLEEP: begin
				ctrl_nxt.cpuHalt = 1'b1;
				ctrl_nxt.sysOscRun = 1'b1;
				ctrl_nxt.portHold = 1'b1;
			end
			pwr_mode_pkg::MODE_SUBSLEEP: begin
				ctrl_nxt.cpuHalt = 1'b1;
				ctrl_nxt.portHold = 1'b1;
			end
			pwr_mode_pkg::MODE_STANDBY: begin
				ctrl_nxt.cpuHalt = 1'b1;
				ctrl_nxt.portHighZ = 1'b1;
			end
			pwr_mode_pkg::MODE_SETTLE: begin
				ctrl_nxt.cpuHalt = 1'b1;
				ctrl_nxt.sysOscRun = 1'b1;
				ctrl_nxt.portHighZ = ~directPend_nxt;
			end
			pwr_mode_pkg::MODE_PIN_RESET: begin
				ctrl_nxt.cpuResetHold = 1'b1;
				ctrl_nxt.sysOscRun = 1'b1;
			end
			pwr_mode_pkg::MODE_SUBACTIVE: begin
				ctrl_nxt.sysOscRun = 1'b0;
			end
			pwr_mode_pkg::MODE_SWITCH: begin
				ctrl_nxt.sysOscRun = ~fromSubSwitch | ~lowSpeed;
			end
			default: begin
				ctrl_nxt.sysOscRun = 1'b1;
			end
		endcase
	end

	// which side a direct switch started from
	always_ff @(posedge clk_sys) begin
		if (rst)
			switchFromSub_r <= 1'b0;
		else if (sleepExec && (mode_r == pwr_mode_pkg::MODE_ACTIVE ||
			mode_r == pwr_mode_pkg::MODE_SUBACTIVE))
			switchFromSub_r <= fromSub;
	end

	// per-module clock gating: run permission by mode, then standby bits
	wire timerRun = mode_nxt != pwr_mode_pkg::MODE_STANDBY &&
		mode_nxt != pwr_mode_pkg::MODE_PIN_RESET;
	wire otherRun = mode_nxt == pwr_mode_pkg::MODE_ACTIVE ||
		mode_nxt == pwr_mode_pkg::MODE_SLEEP ||
		mode_nxt == pwr_mode_pkg::MODE_SUBACTIVE ||
		mode_nxt == pwr_mode_pkg::MODE_SWITCH;
	wire [NUM_MODULES-1:0] standbyNxt =
		wrMsb ? pwdata[NUM_MODULES-1:0] : modStandby_r;
	wire [NUM_MODULES-1:0] modRunNxt;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MODULES; gi++) begin : g_modclk
			assign modRunNxt[gi] = (gi == TIMER_A_INDEX) ?
				timerRun : otherRun;
		end
	endgenerate
	// a standby write gates the clock from the edge it lands on
	always_ff @(posedge clk_sys) begin
		if (rst)
			clkEn_r <= '0;
		else
			clkEn_r <= modRunNxt & ~standbyNxt;
	end

	// APB slave, zero wait: answer in the first access cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= setupPhase;
			pslverr_r <= setupPhase & ~hitAny;
			if (setupPhase)
				prdata_r <= pwrite ? 32'h0000_0000 : readMux;
		end
	end

	// the clear pin wipes the selects like a chip reset
	always_ff @(posedge clk_sys) begin
		if (rst || pinLow) begin
			sysCtrl1_r <= pwr_mode_pkg::SYS_CTRL_1_RST;
			sysCtrl2_r <= pwr_mode_pkg::SYS_CTRL_2_RST;
			modStandby_r <= '0;
		end else begin
			// low nibble of system_control_1 is reserved and reads 0
			if (wrSc1)
				sysCtrl1_r <= {pwdata[7:4], 4'h0};
			if (wrSc2)
				sysCtrl2_r <= pwdata[7:0];
			if (wrMsb)
				modStandby_r <= pwdata[NUM_MODULES-1:0];
		end
	end

	// state, level controls and counters
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_r <= pwr_mode_pkg::MODE_ACTIVE;
			ctrl_r <= '0;
			clkSel_r <= '0;
			cnt_r <= '0;
			noWake_r <= 1'b0;
			directPend_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			ctrl_r <= ctrl_nxt;
			clkSel_r <= clkSel_nxt;
			cnt_r <= cnt_nxt;
			noWake_r <= noWake_nxt;
			directPend_r <= directPend_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign ctrl = ctrl_r;
	assign clkSel = clkSel_r;
	assign moduleClockEn = clkEn_r;
	assign mode = mode_r;

endmodule

// ==== sim/pwr_mode_checker.sv ====
// concurrent checks on the power-down mode controller ports
`timescale 1ns/1ps
module pwr_mode_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic intRequest,
	input wire logic intEnabled,
	input wire logic intMask,
	input wire logic hardwareClearPin_n,
	input wire pwr_mode_pkg::pm_ctrl_s ctrl,
	input wire pwr_mode_pkg::pm_mode_e mode
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	wire logic wake = intRequest && intEnabled && !intMask;
	wire logic pin = hardwareClearPin_n;
	chk_sleep_halt: assert property (
		mode == pwr_mode_pkg::MODE_SLEEP |-> ctrl.cpuHalt)
		else $error("sleep without cpu halt");
	chk_sleep_hold: assert property (
		mode == pwr_mode_pkg::MODE_SLEEP && !wake && pin
		|=> mode == pwr_mode_pkg::MODE_SLEEP) else $error("sleep left");
	chk_exc_run: assert property (
		ctrl.intExcStart |-> mode == pwr_mode_pkg::MODE_ACTIVE
		|| mode == pwr_mode_pkg::MODE_SUBACTIVE) else $error("bad exc mode");
	chk_pin_reset: assert property (
		!pin |=> mode == pwr_mode_pkg::MODE_PIN_RESET && ctrl.cpuResetHold
		&& ctrl.sysOscRun) else $error("pin reset missed");
	chk_standby_off: assert property (
		mode == pwr_mode_pkg::MODE_STANDBY |-> ctrl.portHighZ
		&& !ctrl.sysOscRun) else $error("standby outputs wrong");
	chk_standby_wake: assert property (
		mode == pwr_mode_pkg::MODE_STANDBY && wake && pin
		|=> mode == pwr_mode_pkg::MODE_SETTLE) else $error("no settle");
	chk_standby_hold: assert property (
		mode == pwr_mode_pkg::MODE_STANDBY && !wake && pin
		|=> mode == pwr_mode_pkg::MODE_STANDBY) else $error("standby left");
	chk_subsleep_hold: assert property (
		mode == pwr_mode_pkg::MODE_SUBSLEEP && !wake && pin
		|=> mode == pwr_mode_pkg::MODE_SUBSLEEP) else $error("subsleep left");
	chk_switch_len: assert property (
		disable iff (rst || !pin) $rose(mode == pwr_mode_pkg::MODE_SWITCH)
		|-> (mode == pwr_mode_pkg::MODE_SWITCH) [*4] ##1
		mode != pwr_mode_pkg::MODE_SWITCH) else $error("switch length");
endmodule
bind power_down_mode_control pwr_mode_checker chk (.clk_sys, .rst,
	.intRequest, .intEnabled, .intMask, .hardwareClearPin_n, .ctrl, .mode);

// ==== sim/cpu_irq_model.sv ====
// interrupt source that keeps its request until exception handling starts
`timescale 1ns/1ps
module cpu_irq_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic raise,
	input wire logic excStart,
	output logic intRequest
);
	always_ff @(posedge clk_sys) begin
		if (rst || excStart) begin
			intRequest <= 1'b0;
		end else if (raise) begin
			intRequest <= 1'b1;
		end
	end
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the power-down mode controller
`timescale 1ns/1ps
module tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sleepExec = 1'b0;
	logic raise = 1'b0;
	logic intRequest;
	logic intEnabled = 1'b1;
	logic intMask = 1'b0;
	logic directIntEnabled = 1'b1;
	logic hardwareClearPin_n = 1'b1;
	pwr_mode_pkg::pm_ctrl_s ctrl;
	pwr_mode_pkg::clk_sel_s clkSel;
	logic [7:0] moduleClockEn;
	pwr_mode_pkg::pm_mode_e mode;
	logic [31:0] rd;
	logic slvErr;
	int numErrors = 0;
	int samplesChecked = 0;
	int n;
	localparam int UNIT = 4;
	always #5 clk_sys = ~clk_sys;
	power_down_mode_control #(.NUM_MODULES(8), .TIMER_A_INDEX(0),
		.SETTLE_UNIT(UNIT)) DUT (.clk_sys, .rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .sleepExec, .intRequest,
		.intEnabled, .intMask, .directIntEnabled, .hardwareClearPin_n, .ctrl,
		.clkSel, .moduleClockEn, .mode);
	cpu_irq_model irq_src (.clk_sys, .rst, .raise,
		.excStart(ctrl.intExcStart), .intRequest);
	task automatic stop_test();
		$display("checks %0d errors %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			numErrors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic expMode(input pwr_mode_pkg::pm_mode_e m);
		chk({29'h0, mode}, {29'h0, m});
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		slvErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic goSleep(input logic [7:0] s1, input logic [7:0] s2);
		apb(1'b1, pwr_mode_pkg::OFS_SYS_CTRL_1, s1);
		apb(1'b1, pwr_mode_pkg::OFS_SYS_CTRL_2, s2);
		sleepExec <= 1'b1;
		@(posedge clk_sys);
		sleepExec <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic pulseIrq();
		raise <= 1'b1;
		@(posedge clk_sys);
		raise <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic waitMode(input pwr_mode_pkg::pm_mode_e m);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (mode !== m && n < 100);
		expMode(m);
	endtask
	initial begin
		repeat (2000) @(posedge clk_sys);
		numErrors++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		expMode(pwr_mode_pkg::MODE_ACTIVE);
		chk({24'h0, moduleClockEn}, 32'hFF);
		apb(1'b0, pwr_mode_pkg::OFS_SYS_CTRL_2, 8'h00);
		chk(rd, 32'h0);
		apb(1'b1, pwr_mode_pkg::OFS_SYS_CTRL_2, 8'h05);
		chk({29'h0, clkSel.activeClockSel}, 32'h0);
		goSleep(8'h00, 8'h05);
		expMode(pwr_mode_pkg::MODE_SLEEP);
		chk({31'h0, ctrl.cpuHalt}, 32'h1);
		chk({29'h0, clkSel.activeClockSel}, 32'h5);
		intMask <= 1'b1;
		pulseIrq();
		expMode(pwr_mode_pkg::MODE_SLEEP);
		intMask <= 1'b0;
		waitMode(pwr_mode_pkg::MODE_ACTIVE);
		chk({31'h0, ctrl.intExcStart}, 32'h1);
		goSleep(8'h00, 8'h30);
		pulseIrq();
		expMode(pwr_mode_pkg::MODE_SUBACTIVE);
		chk({30'h0, clkSel.subClockDiv}, 32'h2);
		chk({31'h0, clkSel.lowSpeed}, 32'h1);
		$display("test sleep done");
		goSleep(8'h00, 8'h70); // subclock assumed fitted
		expMode(pwr_mode_pkg::MODE_SUBSLEEP);
		chk({31'h0, ctrl.portHold}, 32'h1);
		chk({24'h0, moduleClockEn}, 32'h01);
		intEnabled <= 1'b0;
		pulseIrq();
		expMode(pwr_mode_pkg::MODE_SUBSLEEP);
		intEnabled <= 1'b1;
		waitMode(pwr_mode_pkg::MODE_SUBACTIVE);
		$display("test subsleep done");
		goSleep(8'h00, 8'h80);
		expMode(pwr_mode_pkg::MODE_SWITCH);
		waitMode(pwr_mode_pkg::MODE_ACTIVE);
		chk(32'(n), 32'(pwr_mode_pkg::SWITCH_CYCLES + UNIT + 2));
		chk({31'h0, ctrl.directExcStart}, 32'h1);
		goSleep(8'h00, 8'hA0);
		waitMode(pwr_mode_pkg::MODE_SUBACTIVE);
		chk(32'(n), 32'h4);
		directIntEnabled <= 1'b0;
		goSleep(8'h00, 8'h80);
		expMode(pwr_mode_pkg::MODE_SLEEP);
		directIntEnabled <= 1'b1;
		pulseIrq();
		expMode(pwr_mode_pkg::MODE_ACTIVE);
		$display("test direct done");
		goSleep(8'h90, 8'h00);
		expMode(pwr_mode_pkg::MODE_STANDBY);
		chk({31'h0, ctrl.portHighZ}, 32'h1);
		intMask <= 1'b1;
		pulseIrq();
		expMode(pwr_mode_pkg::MODE_STANDBY);
		intMask <= 1'b0;
		waitMode(pwr_mode_pkg::MODE_ACTIVE);
		chk(32'(n), 32'((UNIT << 1) + 3));
		$display("test standby done");
		intMask <= 1'b1;
		goSleep(8'h00, 8'h80);
		expMode(pwr_mode_pkg::MODE_SLEEP);
		intMask <= 1'b0;
		pulseIrq();
		expMode(pwr_mode_pkg::MODE_SLEEP);
		hardwareClearPin_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		expMode(pwr_mode_pkg::MODE_PIN_RESET);
		chk({31'h0, ctrl.cpuResetHold}, 32'h1);
		hardwareClearPin_n <= 1'b1;
		waitMode(pwr_mode_pkg::MODE_ACTIVE);
		apb(1'b0, pwr_mode_pkg::OFS_SYS_CTRL_2, 8'h00);
		chk(rd, 32'h0);
		$display("test pin reset done");
		apb(1'b1, pwr_mode_pkg::OFS_MOD_STANDBY, 8'h05);
		chk({24'h0, moduleClockEn}, 32'hFA);
		apb(1'b0, 12'h010, 8'h00);
		chk({31'h0, slvErr}, 32'h1);
		$display("test module standby done");
		stop_test();
	end
endmodule
